// [verilog/mdc_pkg.sv]
`default_nettype none
package mdc_pkg;
  // command block codes
  localparam logic [7:0]  OP_DOWNLOAD  = 8'h3b;
  localparam logic [7:0]  OP_INQUIRY   = 8'h12;
  localparam logic [7:0]  OP_SENSE_REQ = 8'h03;
  localparam logic [2:0]  MODE_SAVE    = 3'h5;
  localparam logic [23:0] IMG_BYTES    = 24'h02ae28;
  localparam logic [23:0] SEG_MASK     = 24'h0003ff;
  localparam int          IMG_WORDS    = 43914;
  localparam int          AW           = 16;

  // completion answers
  localparam logic [3:0] SK_GOOD    = 4'h0;
  localparam logic [3:0] SK_MEDIUM  = 4'h3;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_UNIT_ATT = 4'h6;
  localparam logic [7:0] ASC_UA     = 8'h3f;
  localparam logic [7:0] ASCQ_UA    = 8'h01;
  localparam logic [7:0] FSC_UA     = 8'hc3;
  localparam logic [7:0] ASC_SEQ    = 8'h00;
  localparam logic [7:0] FSC_SEQ    = 8'heb;
  localparam logic [7:0] ASC_FIELD  = 8'h24;
  localparam logic [7:0] CODE_NONE  = 8'h00;

  // apb byte offsets
  localparam logic [7:0] OFS_CDB_LO  = 8'h00;
  localparam logic [7:0] OFS_CDB_MID = 8'h04;
  localparam logic [7:0] OFS_CDB_HI  = 8'h08;
  localparam logic [7:0] OFS_CTRL    = 8'h0c;
  localparam logic [7:0] OFS_DATA    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_SENSE   = 8'h18;

  // control register fields
  localparam int CTRL_ISSUE  = 0;
  localparam int CTRL_ABORT  = 1;
  localparam int CTRL_CLR    = 3;
  localparam int CTRL_ID_LSB = 8;

  // image header check defaults (values arbitrary)
  localparam logic [15:0] HDR_MAGIC  = 16'h5a3c;
  localparam logic [7:0]  HDR_FILES  = 8'h03;

  // phase durations
  localparam longint CLK_HZ      = 20000000;
  localparam longint VALIDATE_S  = 19;
  localparam longint PROGRAM_S   = 16;
  localparam longint SELFTEST_S  = 32;
  localparam int unsigned VALIDATE_CYC = 32'(VALIDATE_S * CLK_HZ);
  localparam int unsigned PROGRAM_CYC  = 32'(PROGRAM_S * CLK_HZ);
  localparam int unsigned SELFTEST_CYC = 32'(SELFTEST_S * CLK_HZ);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RECV  = 5'h02,
    ST_CHECK = 5'h04,
    ST_PROG  = 5'h08,
    ST_POR   = 5'h10
  } mdc_state_e;
endpackage
`default_nettype wire

// [verilog/mdc_mem_if.sv]
`default_nettype none
interface mdc_mem_if #(
  parameter int AW = 16,
  parameter int DW = 32
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                output rd_data);
endinterface
`default_nettype wire

// [verilog/mdc_image_ram.sv]
`default_nettype none
module mdc_image_ram #(
  parameter int DEPTH = 43914,
  parameter int AW    = 16,
  parameter int DW    = 32
) (
  input  wire logic pclk,
  input  wire logic presetn,
  mdc_mem_if.mem    m
);
  typedef struct packed {
    logic [DW-1:0] rd_data;
  } mdc_ram_s;

  logic [DW-1:0] mem [DEPTH];
  mdc_ram_s      r;
  mdc_ram_s      n;

  // array has no reset: contents are only trusted once fully written
  always_ff @(posedge pclk) begin
    if (m.wr_en) begin
      mem[m.wr_addr] <= m.wr_data;
    end
  end

  always_comb begin
    n = r;
    if (m.rd_en) begin
      n.rd_data = mem[m.rd_addr];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign m.rd_data = r.rd_data;
endmodule // mdc_image_ram
`default_nettype wire

// [verilog/mdc_download.sv]
// Functional notes
// - download command recognised by opcode 3Bh in byte 0 of 10-byte block
// - operation type in byte 1 bits 2:0 must be 101b
// - byte 9 bit 7 is segments_follow: one means more commands follow
// - collect image in ram, then check header, files, sum, compatibility
// - program control memory only when every check passes
// - afterwards load power-on defaults and run self-test
// - good to downloader; others get unit attention 6h, 3Fh/01h
// - unit attention carries fault symptom C3h
// - validate about 19 s, program 16 s, reset and self-test 32 s
// - loaded cartridge is unloaded and ejected
// - failed image: check condition, sense 3h, nothing programmed
// - other commands mid-sequence: sense 5h, 00h, symptom EBh; the code lets inquiry 12h and request sense 03h through without it
// - abort during download resets the handler; host restarts
//
// Implementation choices: the APB slave port and the placing of the registers.
`default_nettype none
module mdc_download #(
  parameter int unsigned VAL_CYC   = mdc_pkg::VALIDATE_CYC,
  parameter int unsigned PROG_CYC  = mdc_pkg::PROGRAM_CYC,
  parameter int unsigned POR_CYC   = mdc_pkg::SELFTEST_CYC,
  parameter logic [15:0] MAGIC     = mdc_pkg::HDR_MAGIC,
  parameter logic [7:0]  FILES     = mdc_pkg::HDR_FILES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        cartridge_loaded,
  input  wire logic [7:0]  hw_max_version,
  output var  logic        prog_we,
  output var  logic [15:0] prog_addr,
  output var  logic [31:0] prog_data,
  output var  logic        eject,
  output var  logic        load_defaults,
  output var  logic        selftest
);
  typedef struct packed {
    mdc_pkg::mdc_state_e st;
    logic [31:0] cdb_lo;
    logic [31:0] cdb_mid;
    logic [15:0] cdb_hi;
    logic        in_seq;
    logic [2:0]  owner;
    logic [7:0]  ua_pend;
    logic [23:0] rx_total;
    logic [23:0] seg_left;
    logic        seg_more;
    logic [31:0] csum;
    logic [31:0] header;
    logic [31:0] tmr;
    logic [15:0] rd_addr;
    logic        rd_pv;
    logic [15:0] pv_addr;
    logic        done;
    logic        chk;
    logic [3:0]  key;
    logic [7:0]  asc;
    logic [7:0]  ascq;
    logic [7:0]  fsc;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        prog_we;
    logic [15:0] prog_addr;
    logic [31:0] prog_data;
    logic        eject;
    logic        defaults;
    logic        selftest;
  } mdc_regs_s;
  mdc_regs_s r;
  mdc_regs_s n;
  mdc_mem_if #(.AW(mdc_pkg::AW), .DW(32)) mi ();
  mdc_image_ram #(
    .DEPTH (mdc_pkg::IMG_WORDS),
    .AW    (mdc_pkg::AW),
    .DW    (32)
  ) u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .m       (mi.mem)
  );
  logic        wr_acc;
  logic [7:0]  op;
  logic [7:0]  b1;
  logic [7:0]  bufno;
  logic [23:0] offs;
  logic [23:0] len;
  logic [7:0]  b9;
  logic [23:0] seg_end;
  logic        fields_ok;
  logic [2:0]  id;
  logic [23:0] step;
  logic        img_ok;
  // command block fields, byte n sits in lane n mod 4
  assign op      = r.cdb_lo[7:0];
  assign b1      = r.cdb_lo[15:8];
  assign bufno   = r.cdb_lo[23:16];
  assign offs    = {r.cdb_lo[31:24], r.cdb_mid[7:0], r.cdb_mid[15:8]};
  assign len     = {r.cdb_mid[23:16], r.cdb_mid[31:24], r.cdb_hi[7:0]};
  assign b9      = r.cdb_hi[15:8];
  assign seg_end = offs + len;
  assign id      = pwdata[mdc_pkg::CTRL_ID_LSB +: 3];
  assign step    = (r.seg_left > 24'd4) ? 24'd4 : r.seg_left;
  assign fields_ok = (b1[2:0] == mdc_pkg::MODE_SAVE)
                  && (b1[4:3] == 2'b00)
                  && (bufno == 8'h00)
                  && (offs == (r.in_seq ? r.rx_total : 24'h000000))
                  && (len != 24'h000000)
                  && (b9[6:0] == 7'h00)
                  && (b9[7]
                      ? (((len & mdc_pkg::SEG_MASK) == 24'h000000)
                         && (seg_end < mdc_pkg::IMG_BYTES))
                      : (seg_end == mdc_pkg::IMG_BYTES));
  // a real line-by-line parse is left to firmware; here the image must
  // carry the header word, sum to zero and suit this hardware
  assign img_ok = (r.rx_total == mdc_pkg::IMG_BYTES)
               && (r.csum == 32'h00000000)
               && (r.header[31:16] == MAGIC)
               && (r.header[15:8] == FILES)
               && (r.header[7:0] <= hw_max_version);
  assign wr_acc = psel && penable && pwrite && r.pready;
  always_comb begin
    n             = r;
    n.pready      = psel && !penable;
    n.pslverr     = 1'b0;
    n.prdata      = '0;
    n.prog_we     = 1'b0;
    n.eject       = 1'b0;
    n.defaults    = 1'b0;
    n.rd_pv       = 1'b0;
    mi.wr_en      = 1'b0;
    mi.wr_addr    = r.rx_total[17:2];
    mi.wr_data    = pwdata;
    mi.rd_en      = 1'b0;
    mi.rd_addr    = r.rd_addr;
    // decode in the setup cycle so the answer is a flop in the access
    if (psel && !penable) begin
      case (paddr)
        mdc_pkg::OFS_CDB_LO:  n.prdata = r.cdb_lo;
        mdc_pkg::OFS_CDB_MID: n.prdata = r.cdb_mid;
        mdc_pkg::OFS_CDB_HI:  n.prdata = {16'h0000, r.cdb_hi};
        mdc_pkg::OFS_CTRL: begin
          n.prdata  = {21'h000000, r.owner, 8'h00};
          n.pslverr = pwrite && pwdata[mdc_pkg::CTRL_ISSUE]
                   && (r.st != mdc_pkg::ST_IDLE);
        end
        mdc_pkg::OFS_DATA:
          n.pslverr = !pwrite || (r.st != mdc_pkg::ST_RECV);
        mdc_pkg::OFS_STATUS:
          n.prdata = {r.ua_pend, 11'h000, r.st, 4'h0, r.in_seq,
                      r.selftest, r.chk, r.done};
        mdc_pkg::OFS_SENSE:
          n.prdata = {r.fsc, r.ascq, r.asc, 4'h0, r.key};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        mdc_pkg::OFS_CDB_LO:  n.cdb_lo = pwdata;
        mdc_pkg::OFS_CDB_MID: n.cdb_mid = pwdata;
        mdc_pkg::OFS_CDB_HI:  n.cdb_hi = pwdata[15:0];
        mdc_pkg::OFS_CTRL: begin
          if (pwdata[mdc_pkg::CTRL_CLR]) begin
            n.done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (r.st)
      mdc_pkg::ST_IDLE: begin
        if (wr_acc && paddr == mdc_pkg::OFS_CTRL
            && pwdata[mdc_pkg::CTRL_ISSUE]) begin
          n.done = 1'b1;
          n.chk  = 1'b1;
          n.key  = mdc_pkg::SK_GOOD;
          n.asc  = mdc_pkg::CODE_NONE;
          n.ascq = mdc_pkg::CODE_NONE;
          n.fsc  = mdc_pkg::CODE_NONE;
          if (r.ua_pend[id] && op != mdc_pkg::OP_DOWNLOAD) begin
            n.key  = mdc_pkg::SK_UNIT_ATT;
            n.asc  = mdc_pkg::ASC_UA;
            n.ascq = mdc_pkg::ASCQ_UA;
            n.fsc  = mdc_pkg::FSC_UA;
            n.ua_pend[id] = 1'b0;
          end else if (op != mdc_pkg::OP_DOWNLOAD) begin
            if (r.in_seq && op != mdc_pkg::OP_INQUIRY
                && op != mdc_pkg::OP_SENSE_REQ) begin
              n.key  = mdc_pkg::SK_ILLEGAL;
              n.asc  = mdc_pkg::ASC_SEQ;
              n.ascq = mdc_pkg::CODE_NONE;
              n.fsc  = mdc_pkg::FSC_SEQ;
            end else begin
              n.chk = 1'b0;
            end
          end else if (!fields_ok) begin
            n.key    = mdc_pkg::SK_ILLEGAL;
            n.asc    = mdc_pkg::ASC_FIELD;
            n.in_seq = 1'b0;
          end else begin
            n.chk      = 1'b0;
            n.done     = 1'b0;
            n.owner    = id;
            n.in_seq   = 1'b1;
            n.seg_left = len;
            n.seg_more = b9[7];
            if (offs == 24'h000000) begin
              n.rx_total = '0;
              n.csum     = '0;
            end
            n.st = mdc_pkg::ST_RECV;
          end
        end
      end
      mdc_pkg::ST_RECV: begin
        if (wr_acc && paddr == mdc_pkg::OFS_DATA) begin
          mi.wr_en   = 1'b1;
          n.csum     = r.csum + pwdata;
          n.rx_total = r.rx_total + step;
          n.seg_left = r.seg_left - step;
          if (r.rx_total == 24'h000000) begin
            n.header = pwdata;
          end
          if (r.seg_left == step) begin
            if (r.seg_more) begin
              n.done = 1'b1;
              n.st   = mdc_pkg::ST_IDLE;
            end else begin
              n.tmr = VAL_CYC - 32'd1;
              n.st  = mdc_pkg::ST_CHECK;
            end
          end
        end
      end
      mdc_pkg::ST_CHECK: begin
        n.tmr = r.tmr - 32'd1;
        if (r.tmr == 32'h00000000) begin
          if (img_ok) begin
            n.tmr     = PROG_CYC - 32'd1;
            n.rd_addr = '0;
            n.eject   = cartridge_loaded;
            n.st      = mdc_pkg::ST_PROG;
          end else begin
            n.done   = 1'b1;
            n.chk    = 1'b1;
            n.key    = mdc_pkg::SK_MEDIUM;
            n.asc    = mdc_pkg::CODE_NONE;
            n.in_seq = 1'b0;
            n.st     = mdc_pkg::ST_IDLE;
          end
        end
      end
      mdc_pkg::ST_PROG: begin
        // ram read is one cycle; the word and its address go out together
        if (r.tmr != 32'h00000000) begin
          n.tmr = r.tmr - 32'd1;
        end
        if (r.rd_addr != 16'(mdc_pkg::IMG_WORDS)) begin
          mi.rd_en  = 1'b1;
          n.rd_addr = r.rd_addr + 16'd1;
          n.rd_pv   = 1'b1;
          n.pv_addr = r.rd_addr;
        end
        n.prog_we   = r.rd_pv;
        n.prog_addr = r.pv_addr;
        n.prog_data = mi.rd_data;
        if (r.tmr == 32'h00000000 && !r.rd_pv
            && r.rd_addr == 16'(mdc_pkg::IMG_WORDS)) begin
          n.tmr      = POR_CYC - 32'd1;
          n.defaults = 1'b1;
          n.selftest = 1'b1;
          n.st       = mdc_pkg::ST_POR;
        end
      end
      mdc_pkg::ST_POR: begin
        n.tmr = r.tmr - 32'd1;
        if (r.tmr == 32'h00000000) begin
          n.selftest = 1'b0;
          n.done     = 1'b1;
          n.chk      = 1'b0;
          n.key      = mdc_pkg::SK_GOOD;
          n.asc      = mdc_pkg::CODE_NONE;
          n.ascq     = mdc_pkg::CODE_NONE;
          n.fsc      = mdc_pkg::CODE_NONE;
          n.ua_pend  = ~(8'h01 << r.owner);
          n.in_seq   = 1'b0;
          n.st       = mdc_pkg::ST_IDLE;
        end
      end
      default: n.st = mdc_pkg::ST_IDLE;
    endcase

    // programming cannot be undone, so abort is only honoured before it
    if (wr_acc && paddr == mdc_pkg::OFS_CTRL
        && pwdata[mdc_pkg::CTRL_ABORT]
        && (r.st == mdc_pkg::ST_IDLE || r.st == mdc_pkg::ST_RECV
            || r.st == mdc_pkg::ST_CHECK)) begin
      n.st       = mdc_pkg::ST_IDLE;
      n.in_seq   = 1'b0;
      n.rx_total = '0;
      n.seg_left = '0;
      n.csum     = '0;
      n.chk      = 1'b0;
      n.defaults = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.st <= mdc_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign prog_we       = r.prog_we;
  assign prog_addr     = r.prog_addr;
  assign prog_data     = r.prog_data;
  assign eject         = r.eject;
  assign load_defaults = r.defaults;
  assign selftest      = r.selftest;
endmodule // mdc_download
`default_nettype wire

// [verification/mdc_download_chk.sv]
`default_nettype none
module mdc_download_chk #(
  parameter int unsigned POR_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cartridge_loaded,
  input wire logic        prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic        eject,
  input wire logic        load_defaults,
  input wire logic        selftest
);
  timeunit 1ns;
  timeprecision 1ns;
  // word count restarts with each self-test so a later download checks anew
  logic [15:0] wcnt_r;
  logic [31:0] scnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_r <= 16'h0;
      scnt_r <= 32'h0;
    end else begin
      wcnt_r <= selftest ? 16'h0 : wcnt_r + {15'h0, prog_we};
      scnt_r <= selftest ? scnt_r + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_eject_pulse: assert property (eject |=> !eject)
    else $error("eject longer than one cycle");
  a_eject_cart: assert property (eject |-> $past(cartridge_loaded))
    else $error("eject without cartridge");
  a_prog_order: assert property (prog_we |-> prog_addr == wcnt_r)
    else $error("control memory word out of order");
  a_full_image: assert property ($rose(selftest) |->
    wcnt_r == 16'(mdc_pkg::IMG_WORDS))
    else $error("self-test before whole image programmed");
  a_defaults_first: assert property ($rose(selftest) |->
    load_defaults || $past(load_defaults))
    else $error("self-test without defaults reload");
  a_test_length: assert property ($fell(selftest) |->
    scnt_r == POR_CYC)
    else $error("self-test length wrong");
  a_quiet_test: assert property (selftest |-> !prog_we && !eject)
    else $error("activity during self-test");
endmodule // mdc_download_chk
bind mdc_download mdc_download_chk #(.POR_CYC(POR_CYC)) i_mdc_download_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .cartridge_loaded,
  .prog_we, .prog_addr, .eject, .load_defaults, .selftest
);
`default_nettype wire

// [verification/mdc_mem_model.sv]
`default_nettype none
module mdc_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        prog_we,
  input  wire logic [15:0] prog_addr,
  input  wire logic [31:0] prog_data,
  output var  logic [31:0] words,
  output var  logic [31:0] sum,
  output var  logic [31:0] first
);
  timeunit 1ns;
  timeprecision 1ns;
  // control memory kept as a running sum: storing the image would cost more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words <= 32'h0;
      sum <= 32'h0;
      first <= 32'h0;
    end else if (prog_we) begin
      words <= words + 32'h1;
      sum <= sum + prog_data;
      if (prog_addr == 16'h0) begin
        first <= prog_data;
      end
    end
  end
endmodule // mdc_mem_model
`default_nettype wire

// [verification/mdc_download_bench.sv]
`default_nettype none
module mdc_download_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  ST = mdc_pkg::OFS_STATUS;
  localparam logic [7:0]  SN = mdc_pkg::OFS_SENSE;
  localparam logic [31:0] W0 = {mdc_pkg::HDR_MAGIC, mdc_pkg::HDR_FILES, 8'h07};
  // image writes take two cycles a word, programming one more: about 132k
  localparam int          CAP = 140000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, words, sum, first, prog_data;
  logic [15:0] prog_addr;
  logic        pready, pslverr, err, prog_we, eject, load_defaults;
  int          miscompares = 0, checks = 0, cyc = 0, n_ej = 0, n_ld = 0;
  int          n0;
  mdc_download #(.VAL_CYC(20), .PROG_CYC(10), .POR_CYC(20)) i_mdc_download (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cartridge_loaded(1'b1), .hw_max_version(8'h10),
    .prog_we, .prog_addr, .prog_data, .eject, .load_defaults, .selftest()
  );
  mdc_mem_model i_mdc_mem_model (
    .pclk, .presetn, .prog_we, .prog_addr, .prog_data, .words, .sum, .first
  );
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n_ej <= n_ej + int'(eject);
    n_ld <= n_ld + int'(load_defaults);
    if (cyc == CAP) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // leaves the bus selected so data words can follow back to back
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the cycle ceiling may end a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
    idle();
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] m,
                      logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    idle();
    cmp(nm, e, rd & m);
  endtask
  task automatic cmd(logic [7:0] op, logic [2:0] md, logic [7:0] bn,
                     logic [23:0] of, logic [23:0] ln, logic [1:0] fl,
                     logic [2:0] id);
    wr(mdc_pkg::OFS_CDB_LO, {of[23:16], bn, 5'h0, md, op});
    wr(mdc_pkg::OFS_CDB_MID, {ln[15:8], ln[23:16], of[7:0], of[15:8]});
    wr(mdc_pkg::OFS_CDB_HI, {16'h0, fl, 6'h0, ln[7:0]});
    wr(mdc_pkg::OFS_CTRL, {21'h0, id, 8'h01});
  endtask
  task automatic bad(logic [2:0] md, logic [7:0] bn, logic [23:0] of,
                     logic [23:0] ln, logic [1:0] fl);
    cmd(8'h3b, md, bn, of, ln, fl, 3'h0);
    rchk("field_st", ST, '1, 32'h0000_0103);
    rchk("field_sn", SN, 32'hffff, 32'h2405);
  endtask
  // middle words cancel in pairs and the last cancels the header
  function automatic logic [31:0] img(int i);
    if (i == 0) return W0;
    if (i == mdc_pkg::IMG_WORDS - 1) return -W0;
    return i[0] ? 32'(i) : -32'(i - 1);
  endfunction
  task automatic stream(int lo, int hi);
    for (int i = lo; i < hi; i++) begin
      xfer(1'b1, mdc_pkg::OFS_DATA, img(i));
    end
    idle();
  endtask
  task automatic wait_done;
    do begin
      xfer(1'b0, ST, 32'h0);
      idle();
    end while (rd[0] !== 1'b1);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("reset_st", ST, '1, 32'h0000_0100);
    xfer(1'b0, 8'h1c, 32'h0);
    idle();
    cmp("unmapped", 32'h1, {31'h0, err});
    bad(3'h4, 8'h00, 24'h0, 24'h2ae28, 2'h0);
    bad(3'h5, 8'h01, 24'h0, 24'h2ae28, 2'h0);
    bad(3'h5, 8'h00, 24'h4, 24'h2ae28, 2'h0);
    bad(3'h5, 8'h00, 24'h0, 24'h2ae27, 2'h0);
    bad(3'h5, 8'h00, 24'h0, 24'h3ff, 2'h2);
    bad(3'h5, 8'h00, 24'h0, 24'h2ae28, 2'h1);
    cmd(8'h00, 3'h0, 8'h0, 24'h0, 24'h0, 2'h0, 3'h0);
    rchk("free_st", ST, '1, 32'h0000_0101);
    cmd(8'h3b, 3'h5, 8'h0, 24'h0, 24'h400, 2'h2, 3'h0);
    rchk("recv_st", ST, 32'h1f0f, 32'h0000_0208);
    stream(0, 256);
    rchk("seg_st", ST, '1, 32'h0000_0109);
    cmd(8'h00, 3'h0, 8'h0, 24'h0, 24'h0, 2'h0, 3'h0);
    rchk("mid_st", ST, '1, 32'h0000_010b);
    rchk("mid_sn", SN, '1, 32'heb00_0005);
    cmd(8'h12, 3'h0, 8'h0, 24'h0, 24'h0, 2'h0, 3'h0);
    rchk("inq_st", ST, '1, 32'h0000_0109);
    cmd(8'h3b, 3'h5, 8'h0, 24'h400, 24'h2aa28, 2'h0, 3'h0);
    stream(256, mdc_pkg::IMG_WORDS);
    wait_done();
    rchk("done_st", ST, '1, 32'hfe00_0101);
    rchk("done_sn", SN, '1, 32'h0);
    cmp("words", 32'(mdc_pkg::IMG_WORDS), words);
    cmp("sum", 32'h0, sum);
    cmp("first", W0, first);
    cmp("ejects", 32'h1, 32'(n_ej));
    cmd(8'h12, 3'h0, 8'h0, 24'h0, 24'h0, 2'h0, 3'h2);
    rchk("ua_st", ST, '1, 32'hfa00_0103);
    rchk("ua_sn", SN, '1, 32'hc301_3f06);
    wr(mdc_pkg::OFS_CTRL, 32'h8);
    rchk("clear_st", ST, 32'h1, 32'h0);
    n0 = n_ld;
    cmd(8'h3b, 3'h5, 8'h0, 24'h0, 24'h400, 2'h2, 3'h0);
    stream(0, 8);
    xfer(1'b1, mdc_pkg::OFS_CTRL, 32'h1);
    idle();
    cmp("busy_issue", 32'h1, {31'h0, err});
    rchk("busy_st", ST, 32'h1f08, 32'h0000_0208);
    wr(mdc_pkg::OFS_CTRL, 32'h2);
    rchk("abort_st", ST, 32'h1f08, 32'h0000_0100);
    cmp("defaults", 32'(n0 + 1), 32'(n_ld));
    results();
  end
endmodule // mdc_download_bench
`default_nettype wire
